// ### usart_pkg.sv
package usart_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_DATA  = 3'h0;
	localparam logic [2:0] ADDR_STATA = 3'h1;
	localparam logic [2:0] ADDR_CTRLB = 3'h2;
	localparam logic [2:0] ADDR_CTRLC = 3'h3;
	localparam logic [2:0] ADDR_BAUD  = 3'h4;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int A_RXC  = 7;
	localparam int A_TXC  = 6;
	localparam int A_TXE  = 5;
	localparam int A_FE   = 4;
	localparam int A_OVR  = 3;
	localparam int A_DBL  = 1;
	localparam int A_FILT = 0;
	localparam int B_RXEN = 4;
	localparam int B_TXEN = 3;
	localparam int B_SZ2  = 2;
	localparam int B_RX9  = 1;
	localparam int B_TX9  = 0;
	localparam int C_STOP = 3;
	localparam int C_SZ1  = 2;
	localparam int C_SZ0  = 1;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] SIZE_RST   = 3'h3;
	localparam logic [2:0] SIZE_NINE  = 3'h7;
	localparam logic [4:0] SPB_NORM   = 5'h10;
	localparam logic [4:0] SPB_DBL    = 5'h08;
	localparam logic [4:0] FIRST_NORM = 5'h08;
	localparam logic [4:0] FIRST_DBL  = 5'h04;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;

endpackage : usart_pkg

// ### usart_rx_multidrop_buffer.sv
// Our own choices: the strobed register port and the register offsets.
module usart_rx_multidrop_buffer #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	// Register port
	input  wire logic [2:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	// Serial line
	input  wire logic             serial_in_pin,
	output logic                  serial_out_pin
);

	// ----------------------------------------------------------------
	// Checks and helpers
	// ----------------------------------------------------------------
	if (DIV_W < 1 || DIV_W > 8) begin : g_chk
		$error("DIV_W must lie between 1 and 8");
	end

	function automatic logic maj(input logic a, input logic b, input logic c);
		maj = (a & b) | (a & c) | (b & c);
	endfunction : maj

	function automatic logic [3:0] data_bits(input logic [2:0] code);
		case (code)
			3'h0: data_bits = 4'h5;
			3'h1: data_bits = 4'h6;
			3'h2: data_bits = 4'h7;
			3'h7: data_bits = 4'h9;
			default: data_bits = 4'h8;
		endcase
	endfunction : data_bits

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic             dbl_ff;
	logic             multidrop_filter_en;
	logic             rx_en_ff;
	logic             tx_en_ff;
	logic             stop2_ff;
	logic [2:0]       char_size_code;
	logic             tx_ninth_bit;
	logic [DIV_W-1:0] baud_divisor;
	logic             wr_data;
	logic             rd_data;

	assign wr_data = reg_wr && reg_addr == usart_pkg::ADDR_DATA;
	assign rd_data = reg_rd && reg_addr == usart_pkg::ADDR_DATA;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dbl_ff              <= 1'b0;
			multidrop_filter_en <= 1'b0;
			rx_en_ff            <= 1'b0;
			tx_en_ff            <= 1'b0;
			stop2_ff            <= 1'b0;
			char_size_code      <= usart_pkg::SIZE_RST;
			tx_ninth_bit        <= 1'b0;
			baud_divisor        <= '0;
		end else if (reg_wr) begin
			if (reg_addr == usart_pkg::ADDR_STATA) begin
				dbl_ff              <= reg_wdata[usart_pkg::A_DBL];
				multidrop_filter_en <= reg_wdata[usart_pkg::A_FILT];
			end else if (reg_addr == usart_pkg::ADDR_CTRLB) begin
				rx_en_ff          <= reg_wdata[usart_pkg::B_RXEN];
				tx_en_ff          <= reg_wdata[usart_pkg::B_TXEN];
				char_size_code[2] <= reg_wdata[usart_pkg::B_SZ2];
				tx_ninth_bit      <= reg_wdata[usart_pkg::B_TX9];
			end else if (reg_addr == usart_pkg::ADDR_CTRLC) begin
				stop2_ff            <= reg_wdata[usart_pkg::C_STOP];
				char_size_code[1:0] <= reg_wdata[usart_pkg::C_SZ1:usart_pkg::C_SZ0];
			end else if (reg_addr == usart_pkg::ADDR_BAUD) begin
				baud_divisor <= reg_wdata[DIV_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Sample clock
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] baud_cnt_ff;
	logic             tick;
	logic [4:0]       spb;
	logic [4:0]       sfirst;
	logic [3:0]       nbits;
	logic             nine;

	assign tick   = baud_cnt_ff == '0;
	assign spb    = dbl_ff ? usart_pkg::SPB_DBL : usart_pkg::SPB_NORM;
	assign sfirst = dbl_ff ? usart_pkg::FIRST_DBL : usart_pkg::FIRST_NORM;
	assign nbits  = data_bits(char_size_code);
	assign nine   = char_size_code == usart_pkg::SIZE_NINE;

	always_ff @(posedge mclk) begin
		if (sys_rst || tick) begin
			baud_cnt_ff <= baud_divisor;
		end else begin
			baud_cnt_ff <= baud_cnt_ff - DIV_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Receive line synchroniser
	// ----------------------------------------------------------------
	// The line level only moves once the second and third stages agree.
	logic sync1_ff;
	logic sync2_ff;
	logic sync3_ff;
	logic rxf_ff;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			sync3_ff <= 1'b1;
			rxf_ff   <= 1'b1;
		end else begin
			sync1_ff <= serial_in_pin;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			if (sync2_ff == sync3_ff) begin
				rxf_ff <= sync3_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive state machine
	// ----------------------------------------------------------------
	usart_pkg::rx_state_t rx_st_ff;
	logic [4:0]           rx_cnt_ff;
	logic [3:0]           rx_idx_ff;
	logic [8:0]           rx_sh_ff;
	logic                 v0_ff;
	logic                 v1_ff;
	logic                 vote;
	logic                 vote_pt;
	logic                 frame_done;
	logic                 frame_type;
	logic                 drop;

	assign vote       = maj(v0_ff, v1_ff, rxf_ff);
	assign vote_pt    = tick && rx_st_ff != usart_pkg::RX_IDLE && rx_cnt_ff == sfirst + 5'h2;
	assign frame_done = vote_pt && rx_st_ff == usart_pkg::RX_STOP;
	assign frame_type = nine ? rx_sh_ff[8] : vote;
	assign drop       = multidrop_filter_en && !frame_type;

	always_ff @(posedge mclk) begin
		if (sys_rst || !rx_en_ff) begin
			rx_st_ff  <= usart_pkg::RX_IDLE;
			rx_cnt_ff <= 5'h0;
			rx_idx_ff <= 4'h0;
			rx_sh_ff  <= 9'h000;
			v0_ff     <= 1'b1;
			v1_ff     <= 1'b1;
		end else if (tick) begin
			case (rx_st_ff)
				usart_pkg::RX_IDLE: begin
					if (!rxf_ff) begin
						rx_st_ff  <= usart_pkg::RX_START;
						// The detecting tick is sample one, so the next tick must count as sample two.
						rx_cnt_ff <= 5'h2;
						rx_sh_ff  <= 9'h000;
					end
				end
				default: begin
					if (rx_cnt_ff == sfirst) begin
						v0_ff <= rxf_ff;
					end
					if (rx_cnt_ff == sfirst + 5'h1) begin
						v1_ff <= rxf_ff;
					end
					rx_cnt_ff <= (rx_cnt_ff == spb) ? 5'h1 : rx_cnt_ff + 5'h1;
					if (vote_pt) begin
						if (rx_st_ff == usart_pkg::RX_START && vote) begin
							rx_st_ff <= usart_pkg::RX_IDLE;
						end else if (rx_st_ff == usart_pkg::RX_DATA) begin
							rx_sh_ff[rx_idx_ff] <= vote;
						end else if (rx_st_ff == usart_pkg::RX_STOP) begin
							// Ending at the vote lets the next start bit come early.
							rx_st_ff <= usart_pkg::RX_IDLE;
						end
					end else if (rx_cnt_ff == spb) begin
						if (rx_st_ff == usart_pkg::RX_START) begin
							rx_st_ff  <= usart_pkg::RX_DATA;
							rx_idx_ff <= 4'h0;
						end else if (rx_idx_ff == nbits - 4'h1) begin
							rx_st_ff <= usart_pkg::RX_STOP;
						end else begin
							rx_idx_ff <= rx_idx_ff + 4'h1;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receive FIFO
	// ----------------------------------------------------------------
	logic [9:0] fifo_mem [2];
	logic       wptr_ff;
	logic       rptr_ff;
	logic [1:0] count_ff;
	logic       ovr_ff;
	logic       pop;
	logic       push;
	logic       push_ok;

	assign pop     = rd_data && count_ff != 2'h0;
	assign push    = frame_done && !drop;
	assign push_ok = push && (count_ff != usart_pkg::FIFO_DEPTH || pop);

	always_ff @(posedge mclk) begin
		if (sys_rst || !rx_en_ff) begin
			wptr_ff  <= 1'b0;
			rptr_ff  <= 1'b0;
			count_ff <= 2'h0;
		end else begin
			if (push_ok) begin
				fifo_mem[wptr_ff] <= {!vote, rx_sh_ff};
				wptr_ff           <= !wptr_ff;
			end
			if (pop) begin
				rptr_ff <= !rptr_ff;
			end
			count_ff <= count_ff + {1'b0, push_ok} - {1'b0, pop};
		end
	end

	// A read in the same cycle frees a slot, so the arriving frame is kept and overrun does not set.
	always_ff @(posedge mclk) begin
		if (sys_rst || !rx_en_ff) begin
			ovr_ff <= 1'b0;
		end else if (push && !push_ok) begin
			ovr_ff <= 1'b1;
		end else if (pop) begin
			ovr_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	// The transmitter never looks at the filtering bit.
	logic [7:0]  tx_buffer;
	logic        tx_nine_ff;
	logic        txv_ff;
	logic        busy_ff;
	logic [12:0] tx_sh_ff;
	logic [3:0]  tx_left_ff;
	logic [4:0]  tx_cnt_ff;
	logic        tx_complete_flag;
	logic        out_ff;
	logic        accept;
	logic        load;
	logic        tx_end;
	logic [8:0]  dmask;
	logic [8:0]  tx_word;

	assign accept  = wr_data && !txv_ff;
	assign load    = tx_en_ff && txv_ff && !busy_ff;
	assign tx_end  = busy_ff && tick && tx_cnt_ff == spb - 5'h1 && tx_left_ff == 4'h1;
	assign dmask   = 9'h1FF >> (4'h9 - nbits);
	assign tx_word = {tx_nine_ff, tx_buffer} & dmask | ~dmask;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tx_buffer  <= 8'h00;
			tx_nine_ff <= 1'b0;
			txv_ff     <= 1'b0;
		end else if (accept) begin
			tx_buffer  <= reg_wdata;
			tx_nine_ff <= tx_ninth_bit;
			txv_ff     <= 1'b1;
		end else if (load) begin
			txv_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy_ff    <= 1'b0;
			tx_sh_ff   <= 13'h1FFF;
			tx_left_ff <= 4'h0;
			tx_cnt_ff  <= 5'h0;
		end else if (load) begin
			busy_ff    <= 1'b1;
			tx_sh_ff   <= {3'h7, tx_word, 1'b0};
			tx_left_ff <= 4'h2 + nbits + {3'h0, stop2_ff};
			tx_cnt_ff  <= 5'h0;
		end else if (busy_ff && tick) begin
			if (tx_cnt_ff == spb - 5'h1) begin
				tx_cnt_ff  <= 5'h0;
				tx_sh_ff   <= {1'b1, tx_sh_ff[12:1]};
				tx_left_ff <= tx_left_ff - 4'h1;
				busy_ff    <= !tx_end;
			end else begin
				tx_cnt_ff <= tx_cnt_ff + 5'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			out_ff <= 1'b1;
		end else begin
			out_ff <= busy_ff ? tx_sh_ff[0] : 1'b1;
		end
	end

	// Completion sets over a write-one clear arriving in the same cycle.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tx_complete_flag <= 1'b0;
		end else if (tx_end && !txv_ff) begin
			tx_complete_flag <= 1'b1;
		end else if (reg_wr && reg_addr == usart_pkg::ADDR_STATA && reg_wdata[usart_pkg::A_TXC]) begin
			tx_complete_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [9:0] head;
	logic [7:0] rd_mux;

	assign head = count_ff != 2'h0 ? fifo_mem[rptr_ff] : 10'h000;

	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == usart_pkg::ADDR_DATA) begin
			rd_mux = head[7:0];
		end else if (reg_addr == usart_pkg::ADDR_STATA) begin
			rd_mux[usart_pkg::A_RXC]  = count_ff != 2'h0;
			rd_mux[usart_pkg::A_TXC]  = tx_complete_flag;
			rd_mux[usart_pkg::A_TXE]  = !txv_ff;
			rd_mux[usart_pkg::A_FE]   = head[9];
			rd_mux[usart_pkg::A_OVR]  = ovr_ff;
			rd_mux[usart_pkg::A_DBL]  = dbl_ff;
			rd_mux[usart_pkg::A_FILT] = multidrop_filter_en;
		end else if (reg_addr == usart_pkg::ADDR_CTRLB) begin
			rd_mux[usart_pkg::B_RXEN] = rx_en_ff;
			rd_mux[usart_pkg::B_TXEN] = tx_en_ff;
			rd_mux[usart_pkg::B_SZ2]  = char_size_code[2];
			rd_mux[usart_pkg::B_RX9]  = head[8];
			rd_mux[usart_pkg::B_TX9]  = tx_ninth_bit;
		end else if (reg_addr == usart_pkg::ADDR_CTRLC) begin
			rd_mux[usart_pkg::C_STOP] = stop2_ff;
			rd_mux[usart_pkg::C_SZ1]  = char_size_code[1];
			rd_mux[usart_pkg::C_SZ0]  = char_size_code[0];
		end else if (reg_addr == usart_pkg::ADDR_BAUD) begin
			rd_mux[DIV_W-1:0] = baud_divisor;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	assign serial_out_pin = out_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_wrap;
		@(posedge mclk) disable iff (sys_rst)
		(rx_en_ff && tick && rx_st_ff != usart_pkg::RX_IDLE && rx_cnt_ff == spb) |=> rx_cnt_ff == 5'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("sample counter did not wrap");

	property p_start_reject;
		@(posedge mclk) disable iff (sys_rst)
		(rx_en_ff && vote_pt && rx_st_ff == usart_pkg::RX_START && vote) |=> rx_st_ff == usart_pkg::RX_IDLE;
	endproperty
	a_start_reject: assert property (p_start_reject) else $error("noise start accepted");

	property p_drop;
		@(posedge mclk) disable iff (sys_rst)
		(rx_en_ff && frame_done && drop && !pop) |=> count_ff == $past(count_ff) && !$rose(ovr_ff);
	endproperty
	a_drop: assert property (p_drop) else $error("dropped frame changed buffer");

	property p_addr_kept;
		@(posedge mclk) disable iff (sys_rst)
		(rx_en_ff && frame_done && frame_type && count_ff == 2'h0) |=> count_ff == 2'h1;
	endproperty
	a_addr_kept: assert property (p_addr_kept) else $error("address frame lost");

	property p_rxc;
		@(posedge mclk) disable iff (sys_rst)
		(reg_rd && reg_addr == usart_pkg::ADDR_STATA) |=> reg_rdata[usart_pkg::A_RXC] == ($past(count_ff) != 2'h0);
	endproperty
	a_rxc: assert property (p_rxc) else $error("receive complete wrong");

	property p_pop;
		@(posedge mclk) disable iff (sys_rst)
		(rx_en_ff && rd_data && count_ff != 2'h0 && !push) |=> count_ff == $past(count_ff) - 2'h1;
	endproperty
	a_pop: assert property (p_pop) else $error("read did not advance FIFO");

	property p_ignore_wr;
		@(posedge mclk) disable iff (sys_rst)
		(wr_data && txv_ff) |=> tx_buffer == $past(tx_buffer);
	endproperty
	a_ignore_wr: assert property (p_ignore_wr) else $error("full buffer overwritten");

	property p_load;
		@(posedge mclk) disable iff (sys_rst)
		load |=> busy_ff && !txv_ff ##1 out_ff == 1'b0;
	endproperty
	a_load: assert property (p_load) else $error("transmit load failed");

endmodule : usart_rx_multidrop_buffer

// ### usart_line_peer.sv
module usart_line_peer (
	// Clock
	input  wire logic mclk,
	// Serial line
	input  wire logic dut_tx,
	output logic      line_out
);
	timeunit 1ns;
	timeprecision 1ps;

	int         tx_bclk = 16;
	int         tx_bits = 8;
	logic [9:0] got_q[$];
	logic [8:0] acc;

	initial line_out = 1'h1;

	// ----------------------------------------------------------------
	// Frame sender
	// ----------------------------------------------------------------
	// Bit time is exact; the bench picks offsets within half the total error.
	task automatic send(input logic [8:0] d, input int nbit, input logic ftype, input int nstop, input int bclk);
		line_out <= 1'h0;
		repeat (bclk) @(posedge mclk);
		for (int i = 0; i < nbit; i++) begin
			line_out <= d[i];
			repeat (bclk) @(posedge mclk);
		end
		line_out <= ftype;
		repeat (bclk) @(posedge mclk);
		// A one-stop frame already ends high, and a release here would clash with the next start.
		if (nstop > 1) begin
			line_out <= 1'h1;
			repeat ((nstop - 1) * bclk) @(posedge mclk);
		end
	endtask : send

	// ----------------------------------------------------------------
	// Frame catcher
	// ----------------------------------------------------------------
	// Samples mid-bit, so one clock of launch skew cannot flip a bit.
	always begin
		@(negedge dut_tx);
		acc = '0;
		repeat (tx_bclk / 2) @(posedge mclk);
		for (int i = 0; i < tx_bits; i++) begin
			repeat (tx_bclk) @(posedge mclk);
			acc[i] = dut_tx;
		end
		repeat (tx_bclk) @(posedge mclk);
		got_q.push_back({dut_tx, acc});
	end

endmodule : usart_line_peer

// ### usart_rx_multidrop_buffer_tb.sv
module usart_rx_multidrop_buffer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [2:0] AD = usart_pkg::ADDR_DATA;
	localparam logic [2:0] AS = usart_pkg::ADDR_STATA;
	localparam logic [2:0] AB = usart_pkg::ADDR_CTRLB;
	localparam logic [2:0] AC = usart_pkg::ADDR_CTRLC;

	logic       mclk;
	logic       sys_rst;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       rx_line;
	logic       tx_line;
	int         error_cnt;
	int         n_checks;
	int         seed;
	int         cyc;
	logic [7:0] rv;
	logic [8:0] d;
	logic [7:0] q[3];

	usart_rx_multidrop_buffer #(.DIV_W(8)) DUT (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(rx_line), .serial_out_pin(tx_line));
	usart_line_peer peer (.mclk(mclk), .dut_tx(tx_line), .line_out(rx_line));

	initial mclk = 1'h0;
	always #5 mclk = ~mclk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'h1;
		@(posedge mclk);
		reg_wr    <= 1'h0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge mclk);
		reg_rd   <= 1'h0;
		#1 v = reg_rdata;
	endtask : rd

	function automatic int nb(input logic [2:0] s);
		return (s == usart_pkg::SIZE_NINE) ? 9 : (s > 3'h3) ? 8 : int'(s) + 5;
	endfunction : nb

	function automatic logic [8:0] mask(input logic [8:0] v, input logic [2:0] s);
		return v & 9'((10'h1 << nb(s)) - 10'h1);
	endfunction : mask

	// Whole-byte writes only, so the completion flag is never hit by accident.
	task automatic cfg(input logic [2:0] s, input logic f, input logic dbl, input logic [7:0] dv);
		wr(usart_pkg::ADDR_BAUD, dv);
		wr(AC, {5'h0, s[1:0], 1'h0});
		wr(AB, {3'h0, 2'h3, s[2], 2'h0});
		wr(AS, {6'h0, dbl, f});
		peer.tx_bits = nb(s);
		peer.tx_bclk = (dbl ? 8 : 16) * (int'(dv) + 1);
	endtask : cfg

	task automatic wait_q(input int n);
		for (int k = 0; k < 3000 && peer.got_q.size() < n; k++) @(posedge mclk);
		chk(peer.got_q.size(), n);
	endtask : wait_q

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed      = 32'hDE1E;
		cyc       = 0;
		error_cnt = 0;
		n_checks  = 0;
		sys_rst   = 1'h1;
		reg_addr  = 3'h0;
		reg_wdata = 8'h0;
		reg_wr    = 1'h0;
		reg_rd    = 1'h0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'h0;
		rd(AS, rv);
		chk(rv, 8'h20);
		rd(AB, rv);
		chk(rv, 8'h00);
		rd(AC, rv);
		chk(rv, 8'h06);
		wr(3'h6, 8'hFF);
		rd(3'h6, rv);
		chk(rv, 8'h00);
		for (int s = 0; s < 4; s++) begin
			cfg(3'(s), 1'h0, 1'h0, 8'h0);
			d = 9'($random(seed));
			peer.send(d, nb(3'(s)), 1'h1, 1, 16);
			repeat (20) @(posedge mclk);
			rd(AD, rv);
			chk(rv, mask(d, 3'(s)));
			wr(AD, d[7:0]);
			wait_q(1);
			chk(peer.got_q.pop_front(), {1'h1, mask(d, 3'(s))});
		end
		cfg(3'h3, 1'h0, 1'h0, 8'h1);
		for (int i = 0; i < 3; i++) begin
			q[i] = 8'($random(seed));
			peer.send({1'h0, q[i]}, 8, 1'h1, 1, 31 + i);
		end
		repeat (20) @(posedge mclk);
		rd(AS, rv);
		chk({rv[7], rv[3]}, 2'h3);
		for (int i = 0; i < 2; i++) begin
			rd(AD, rv);
			chk(rv, q[i]);
		end
		rd(AS, rv);
		chk({rv[7], rv[3]}, 2'h0);
		cfg(3'h3, 1'h0, 1'h1, 8'h0);
		d = 9'($random(seed));
		peer.send(d, 8, 1'h1, 1, 8);
		repeat (20) @(posedge mclk);
		rd(AD, rv);
		chk(rv, d[7:0]);
		wr(AD, d[7:0]);
		wait_q(1);
		chk(peer.got_q.pop_front(), {2'h2, d[7:0]});
		cfg(3'h3, 1'h0, 1'h0, 8'h0);
		peer.line_out <= 1'h0;
		repeat (6) @(posedge mclk);
		peer.line_out <= 1'h1;
		repeat (40) @(posedge mclk);
		rd(AS, rv);
		chk(rv[7], 1'h0);
		peer.send(d, 8, 1'h1, 1, 16);
		repeat (20) @(posedge mclk);
		rd(AD, rv);
		chk(rv, d[7:0]);
		peer.line_out <= 1'h0;
		repeat (9) @(posedge mclk);
		peer.line_out <= 1'h1;
		repeat (200) @(posedge mclk);
		rd(AD, rv);
		chk(rv, 8'hFF);
		cfg(3'h7, 1'h1, 1'h0, 8'h0);
		peer.send({1'h0, q[0]}, 9, 1'h1, 1, 16);
		repeat (20) @(posedge mclk);
		rd(AS, rv);
		chk({rv[7], rv[4], rv[3]}, 3'h0);
		peer.send({1'h1, q[1]}, 9, 1'h1, 1, 16);
		repeat (20) @(posedge mclk);
		rd(AS, rv);
		chk(rv[7], 1'h1);
		rd(AB, rv);
		chk(rv[1], 1'h1);
		rd(AD, rv);
		chk(rv, q[1]);
		wr(AS, 8'h00);
		peer.send({1'h0, q[2]}, 9, 1'h1, 1, 16);
		repeat (20) @(posedge mclk);
		rd(AB, rv);
		chk(rv[1], 1'h0);
		rd(AD, rv);
		chk(rv, q[2]);
		wr(AS, 8'h01);
		wr(AB, 8'h1D);
		wr(AD, q[0]);
		wait_q(1);
		chk(peer.got_q.pop_front(), {2'h3, q[0]});
		wr(AB, 8'h1C);
		wr(AD, q[0]);
		repeat (4) @(posedge mclk);
		reg_wdata <= q[1];
		reg_wr    <= 1'h1;
		@(posedge mclk);
		reg_wdata <= q[2];
		@(posedge mclk);
		reg_wr    <= 1'h0;
		wait_q(2);
		chk(peer.got_q.pop_front(), {2'h2, q[0]});
		chk(peer.got_q.pop_front(), {2'h2, q[1]});
		repeat (400) @(posedge mclk);
		chk(peer.got_q.size(), 0);
		cfg(3'h3, 1'h1, 1'h0, 8'h0);
		peer.send({1'h0, q[0]}, 8, 1'h0, 2, 16);
		repeat (20) @(posedge mclk);
		rd(AS, rv);
		chk({rv[7], rv[4], rv[3]}, 3'h0);
		peer.send({1'h0, q[1]}, 8, 1'h1, 2, 16);
		repeat (20) @(posedge mclk);
		rd(AD, rv);
		chk(rv, q[1]);
		rd(AS, rv);
		chk(rv[6], 1'h1);
		wr(AS, 8'h41);
		rd(AS, rv);
		chk(rv[6], 1'h0);
		wr(AC, 8'h0E);
		wr(AD, q[2]);
		wait_q(1);
		chk(peer.got_q.pop_front(), {2'h2, q[2]});
		repeat (14) @(posedge mclk);
		rd(AS, rv);
		chk(rv[6], 1'h0);
		repeat (20) @(posedge mclk);
		rd(AS, rv);
		chk(rv[6], 1'h1);
		conclude();
	end

endmodule : usart_rx_multidrop_buffer_tb
